//--- srlc_pkg.sv
`default_nettype none

package srlc_pkg;

    // Bus geometry
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned N_AREAS = 4;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] TXPTR_OFS = 8'h04;
    localparam logic [7:0] RXPTR_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS  = 8'h0c;

    // Control register fields
    localparam int unsigned LED_MODE_BIT   = 14;
    localparam int unsigned POL_BIT        = 15;
    localparam int unsigned GLOBAL_BIT     = 16;
    localparam int unsigned RX_BIT         = 17;
    localparam int unsigned TX_BIT         = 18;
    localparam int unsigned DMA_SEL_BIT    = 19;
    localparam int unsigned FIFO_SEL_BIT   = 20;
    localparam int unsigned RESET_IN_PROGRESS_OUT_SEL_BIT = 24;

    // Status register fields
    localparam int unsigned STAT_TXDONE_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT   = 1;

    // Reset values
    localparam logic        LED_MODE_RST = 1'b0;
    localparam logic        POL_RST      = 1'b0;
    localparam logic [31:0] PTR_RST      = 32'h0000_0000;

    // Timing
    localparam int unsigned CLK_NS          = 25;
    localparam int unsigned BLINK_LOW_NS    = 5240000;
    localparam int unsigned BLINK_PERIOD_NS = 41890000;
    localparam int unsigned BLINK_LOW_CYCLES    = BLINK_LOW_NS / CLK_NS;
    localparam int unsigned BLINK_PERIOD_CYCLES = BLINK_PERIOD_NS / CLK_NS;
    localparam int unsigned RESET_HOLD_NS     = 400;
    localparam int unsigned RESET_HOLD_CYCLES =
        (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        SRLC_IDLE = 3'b001,
        SRLC_HOLD = 3'b010,
        SRLC_DONE = 3'b100
    } srlc_state_t;

endpackage : srlc_pkg

`default_nettype wire

//--- srlc_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none

module srlc_reset_sync (
    input  wire logic ref_clk,
    input  wire logic resetn,
    output var  logic rst_n
);

    logic stage1;
    logic next_stage1;
    logic next_rst_n;

    always_comb begin
        next_stage1 = 1'b1;
        next_rst_n  = stage1;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            rst_n  <= next_rst_n;
        end
    end

endmodule : srlc_reset_sync

`default_nettype wire

//--- srlc_blink_timer.sv
`timescale 1ns/1ps
`default_nettype none

module srlc_blink_timer #(
    parameter int unsigned LOW_CYCLES    = srlc_pkg::BLINK_LOW_CYCLES,
    parameter int unsigned PERIOD_CYCLES = srlc_pkg::BLINK_PERIOD_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    output var  logic lit
);

    localparam logic [20:0] LOW_W  = 21'(LOW_CYCLES);
    localparam logic [20:0] LAST_W = 21'(PERIOD_CYCLES - 1);

    logic [20:0] cnt;
    logic [20:0] next_cnt;

    // Restarts at the lit phase whenever blinking is requested anew
    always_comb begin
        next_cnt = 21'h000000;
        if (enable && cnt != LAST_W) begin
            next_cnt = cnt + 21'h000001;
        end
        lit = enable && (cnt < LOW_W);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 21'h000000;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule : srlc_blink_timer

`default_nettype wire

//--- srlc_reset_led.sv
// Behaviour
// - Duplex pin low; collision blinks or holds high
// - Reset-active output level follows polarity bit
// - Global command resets all selected areas
// - Global reset hits transmit and receive portions
// - Global command bit clears itself when done
// - Configuration space untouched by global reset
// - Receive command resets only receive portions
// - Receive command bit clears itself when done
// - Transmit command resets transmit portions, self-clears
// - DMA select includes or excludes DMA area
// - DMA select bit clears itself after use
// - DMA reset clears pointers and done flag
// - Mode bit picks indicator mode 0 or 1
// - Blink period 41.89ms, lit 5.24ms
`timescale 1ns/1ps
`default_nettype none

module srlc_reset_led #(
    parameter int unsigned BLINK_LOW_CYCLES    = srlc_pkg::BLINK_LOW_CYCLES,
    parameter int unsigned BLINK_PERIOD_CYCLES =
        srlc_pkg::BLINK_PERIOD_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output var  logic [31:0] bus_rdata,
    input  wire logic        full_duplex_cfg,
    input  wire logic        collision_detected,
    input  wire logic        tx_dma_done_in,
    output var  logic        duplex_indicator_pin,
    output var  logic        reset_in_progress_out,
    output var  logic        dma_tx_logic_reset,
    output var  logic        dma_rx_logic_reset,
    output var  logic [3:0]  area_tx_reset,
    output var  logic [3:0]  area_rx_reset,
    output var  logic [31:0] tx_descriptor_list_pointer,
    output var  logic [31:0] rx_descriptor_list_pointer,
    output var  logic        tx_transfer_done_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release and decode

    localparam logic [7:0] HOLD_LAST = 8'(srlc_pkg::RESET_HOLD_CYCLES - 1);

    logic rst_n;

    srlc_reset_sync u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .rst_n   (rst_n)
    );

    logic ctrl_wr;
    logic txptr_wr;
    logic rxptr_wr;
    logic stat_wr;

    assign ctrl_wr  = bus_wr && bus_addr == srlc_pkg::CTRL_OFS;
    assign txptr_wr = bus_wr && bus_addr == srlc_pkg::TXPTR_OFS;
    assign rxptr_wr = bus_wr && bus_addr == srlc_pkg::RXPTR_OFS;
    assign stat_wr  = bus_wr && bus_addr == srlc_pkg::STAT_OFS;

    ////////////////////////////////////////////////////////////////////////
    // Soft reset sequencer

    srlc_pkg::srlc_state_t state;
    srlc_pkg::srlc_state_t next_state;
    logic [7:0]            cnt;
    logic [7:0]            next_cnt;
    logic [2:0]            cmd;
    logic [2:0]            next_cmd;
    logic [5:0]            sel;
    logic [5:0]            next_sel;
    logic [2:0]            wr_cmd;

    // cmd: 0 global, 1 receive, 2 transmit
    // sel: 0 DMA, 1..4 other areas, 5 reset output
    assign wr_cmd = bus_wdata[srlc_pkg::TX_BIT:srlc_pkg::GLOBAL_BIT];

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_cmd   = cmd;
        next_sel   = sel;
        case (state)
            srlc_pkg::SRLC_IDLE: begin
                // Commands arriving mid-sequence are dropped
                if (ctrl_wr && wr_cmd != 3'h0) begin
                    next_state = srlc_pkg::SRLC_HOLD;
                    next_cnt   = HOLD_LAST;
                    next_cmd   = wr_cmd;
                    next_sel   = bus_wdata[srlc_pkg::RESET_IN_PROGRESS_OUT_SEL_BIT:
                                           srlc_pkg::DMA_SEL_BIT];
                end
            end
            srlc_pkg::SRLC_HOLD: begin
                if (cnt == 8'h00) begin
                    next_state = srlc_pkg::SRLC_DONE;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            srlc_pkg::SRLC_DONE: begin
                next_state = srlc_pkg::SRLC_IDLE;
                next_cmd   = 3'h0;
                next_sel   = 6'h00;
            end
            default: begin
                next_state = srlc_pkg::SRLC_IDLE;
                next_cnt   = 8'h00;
                next_cmd   = 3'h0;
                next_sel   = 6'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= srlc_pkg::SRLC_IDLE;
            cnt   <= 8'h00;
            cmd   <= 3'h0;
            sel   <= 6'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            cmd   <= next_cmd;
            sel   <= next_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator configuration

    logic led_mode;
    logic next_led_mode;
    logic polarity;
    logic next_polarity;

    always_comb begin
        next_led_mode = led_mode;
        next_polarity = polarity;
        if (ctrl_wr) begin
            next_led_mode = bus_wdata[srlc_pkg::LED_MODE_BIT];
            next_polarity = bus_wdata[srlc_pkg::POL_BIT];
        end
        // Only the reset-output area returns to defaults; nothing of the
        // configuration space lives here
        if (state == srlc_pkg::SRLC_DONE && cmd[0] && sel[5]) begin
            next_led_mode = srlc_pkg::LED_MODE_RST;
            next_polarity = srlc_pkg::POL_RST;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            led_mode <= srlc_pkg::LED_MODE_RST;
            polarity <= srlc_pkg::POL_RST;
        end else begin
            led_mode <= next_led_mode;
            polarity <= next_polarity;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Area reset outputs

    logic       next_hold;
    logic       next_tx_do;
    logic       next_rx_do;
    logic       next_dma_tx;
    logic       next_dma_rx;
    logic [3:0] next_area_tx;
    logic [3:0] next_area_rx;
    logic       next_rst_out;

    always_comb begin
        next_hold  = next_state == srlc_pkg::SRLC_HOLD;
        next_tx_do = next_hold && (next_cmd[0] || next_cmd[2]);
        next_rx_do = next_hold && (next_cmd[0] || next_cmd[1]);
        next_dma_tx = next_tx_do && next_sel[0];
        next_dma_rx = next_rx_do && next_sel[0];
        // Asserted over the whole sequence, release cycle included
        next_rst_out = (next_state != srlc_pkg::SRLC_IDLE) ?
                       next_polarity : !next_polarity;
    end

    for (genvar i = 0; i < 4; i++) begin : g_area
        assign next_area_tx[i] = next_tx_do && next_sel[i+1];
        assign next_area_rx[i] = next_rx_do && next_sel[i+1];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_tx_logic_reset    <= 1'b0;
            dma_rx_logic_reset    <= 1'b0;
            area_tx_reset         <= 4'h0;
            area_rx_reset         <= 4'h0;
            reset_in_progress_out <= !srlc_pkg::POL_RST;
        end else begin
            dma_tx_logic_reset    <= next_dma_tx;
            dma_rx_logic_reset    <= next_dma_rx;
            area_tx_reset         <= next_area_tx;
            area_rx_reset         <= next_area_rx;
            reset_in_progress_out <= next_rst_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA area registers

    logic [31:0] next_txptr;
    logic [31:0] next_rxptr;
    logic        next_txdone;

    always_comb begin
        next_txptr  = tx_descriptor_list_pointer;
        next_rxptr  = rx_descriptor_list_pointer;
        next_txdone = tx_transfer_done_flag;
        if (txptr_wr) begin
            next_txptr = bus_wdata;
        end
        if (rxptr_wr) begin
            next_rxptr = bus_wdata;
        end
        if (stat_wr && bus_wdata[srlc_pkg::STAT_TXDONE_BIT]) begin
            next_txdone = 1'b0;
        end
        // A new completion beats a software clear
        if (tx_dma_done_in) begin
            next_txdone = 1'b1;
        end
        if (next_dma_tx) begin
            next_txptr  = srlc_pkg::PTR_RST;
            next_txdone = 1'b0;
        end
        if (next_dma_rx) begin
            next_rxptr = srlc_pkg::PTR_RST;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_descriptor_list_pointer <= srlc_pkg::PTR_RST;
            rx_descriptor_list_pointer <= srlc_pkg::PTR_RST;
            tx_transfer_done_flag      <= 1'b0;
        end else begin
            tx_descriptor_list_pointer <= next_txptr;
            rx_descriptor_list_pointer <= next_rxptr;
            tx_transfer_done_flag      <= next_txdone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (bus_rd) begin
            case (bus_addr)
                srlc_pkg::CTRL_OFS: begin
                    next_rdata[srlc_pkg::LED_MODE_BIT] = led_mode;
                    next_rdata[srlc_pkg::POL_BIT]      = polarity;
                    next_rdata[srlc_pkg::TX_BIT:srlc_pkg::GLOBAL_BIT] = cmd;
                    next_rdata[srlc_pkg::RESET_IN_PROGRESS_OUT_SEL_BIT:
                               srlc_pkg::DMA_SEL_BIT] = sel;
                end
                srlc_pkg::TXPTR_OFS: next_rdata = tx_descriptor_list_pointer;
                srlc_pkg::RXPTR_OFS: next_rdata = rx_descriptor_list_pointer;
                srlc_pkg::STAT_OFS: begin
                    next_rdata[srlc_pkg::STAT_TXDONE_BIT] =
                        tx_transfer_done_flag;
                    next_rdata[srlc_pkg::STAT_BUSY_BIT] =
                        state != srlc_pkg::SRLC_IDLE;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 32'h0000_0000;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duplex indicator

    logic blink_en;
    logic blink_lit;
    logic next_duplex_pin;

    assign blink_en = !full_duplex_cfg && collision_detected && !led_mode;

    srlc_blink_timer #(
        .LOW_CYCLES    (BLINK_LOW_CYCLES),
        .PERIOD_CYCLES (BLINK_PERIOD_CYCLES)
    ) u_blink (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .enable  (blink_en),
        .lit     (blink_lit)
    );

    always_comb begin
        next_duplex_pin = 1'b1;
        if (full_duplex_cfg) begin
            next_duplex_pin = 1'b0;
        end else if (collision_detected) begin
            next_duplex_pin = led_mode ? 1'b1 : !blink_lit;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            duplex_indicator_pin <= 1'b1;
        end else begin
            duplex_indicator_pin <= next_duplex_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    localparam int SEQ_SPAN = int'(srlc_pkg::RESET_HOLD_CYCLES) + 2;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_req(int b);
        ctrl_wr && bus_wdata[b] && state == srlc_pkg::SRLC_IDLE;
    endsequence

    sequence s_release;
        state == srlc_pkg::SRLC_IDLE && cmd == 3'h0 && sel == 6'h00;
    endsequence

    a_global_self_clear: assert property (
        s_req(srlc_pkg::GLOBAL_BIT) |-> ##[SEQ_SPAN:SEQ_SPAN] s_release)
        else $error("global command did not clear on time");

    a_rx_self_clear: assert property (
        s_req(srlc_pkg::RX_BIT) |-> ##[SEQ_SPAN:SEQ_SPAN] s_release)
        else $error("receive command did not clear on time");

    a_global_both_sides: assert property (
        s_req(srlc_pkg::GLOBAL_BIT) ##0 bus_wdata[srlc_pkg::DMA_SEL_BIT]
        |=> (dma_tx_logic_reset && dma_rx_logic_reset)[*8])
        else $error("global reset missed a side of the DMA area");

    a_rx_only_side: assert property (
        state == srlc_pkg::SRLC_HOLD && cmd == 3'h2
        |-> !dma_tx_logic_reset && area_tx_reset == 4'h0)
        else $error("receive reset touched transmit logic");

    a_dma_excluded: assert property (
        state != srlc_pkg::SRLC_IDLE && !sel[0]
        |-> !dma_tx_logic_reset && !dma_rx_logic_reset)
        else $error("DMA area reset while not selected");

    a_dma_tx_clears: assert property (
        dma_tx_logic_reset
        |-> tx_descriptor_list_pointer == 32'h0000_0000
            && !tx_transfer_done_flag)
        else $error("transmit DMA state not cleared");

    a_reset_in_progress_out_level: assert property (
        state != srlc_pkg::SRLC_IDLE && $stable(polarity)
        |-> reset_in_progress_out == polarity)
        else $error("reset output has wrong level");

    a_reset_in_progress_out_ends: assert property (
        state == srlc_pkg::SRLC_DONE && !ctrl_wr
        |=> reset_in_progress_out == !polarity)
        else $error("reset output not released after sequence");

    a_duplex_full: assert property (
        full_duplex_cfg |=> duplex_indicator_pin == 1'b0)
        else $error("duplex pin not low in full duplex");

    a_collision_mode1: assert property (
        !full_duplex_cfg && collision_detected && led_mode && !ctrl_wr
        |=> duplex_indicator_pin == 1'b1)
        else $error("duplex pin not steady high in mode 1");

    a_blink_starts_lit: assert property (
        blink_en && !$past(blink_en) && !ctrl_wr
        |=> duplex_indicator_pin == 1'b0)
        else $error("blink did not start in the lit phase");

endmodule : srlc_reset_led

`default_nettype wire

//--- srlc_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module srlc_far_side (
    input  wire logic ref_clk,
    input  wire logic clr,
    input  wire logic pol,
    input  wire logic reset_in_progress_out,
    input  wire logic duplex_indicator_pin,
    output var  int   rst_cycles,
    output var  int   lit_cycles
);

    // Reset consumer counts active cycles, indicator counts lit cycles
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            rst_cycles <= 0;
            lit_cycles <= 0;
        end else begin
            if (reset_in_progress_out == pol) begin
                rst_cycles <= rst_cycles + 1;
            end
            if (!duplex_indicator_pin) begin
                lit_cycles <= lit_cycles + 1;
            end
        end
    end

endmodule : srlc_far_side

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %0t %s got %h exp %h", $time, m, g, e); \
    end end

module tb;
    localparam int unsigned LOW = 4;
    localparam int unsigned PER = 16;
    localparam logic [7:0]  OFS_BAD = 8'h10;

    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic        full_duplex_cfg = 1'b0;
    logic        collision_detected = 1'b0;
    logic        tx_dma_done_in = 1'b0;
    logic        duplex_indicator_pin;
    logic        reset_in_progress_out;
    logic        dma_tx_logic_reset;
    logic        dma_rx_logic_reset;
    logic [3:0]  area_tx_reset;
    logic [3:0]  area_rx_reset;
    logic [31:0] tx_ptr;
    logic [31:0] rx_ptr;
    logic        tx_done_flag;
    logic        clr = 1'b1;
    logic        pol = 1'b0;
    int          rst_cycles;
    int          lit_cycles;
    int          error_cnt = 0;
    int          comparisons = 0;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    logic        rd_q = 1'b0;
    logic [31:0] lfsr_state = 32'h0001_3a3a;
    logic [3:0]  plan [5] = '{4'b1001, 4'b1010, 4'b1100, 4'b0100, 4'b1011};

    always #12.5 ref_clk = ~ref_clk;

    srlc_reset_led #(
        .BLINK_LOW_CYCLES    (LOW),
        .BLINK_PERIOD_CYCLES (PER)
    ) srlc_reset_led_inst (
        .ref_clk                    (ref_clk),
        .resetn                     (resetn),
        .bus_addr                   (bus_addr),
        .bus_wdata                  (bus_wdata),
        .bus_wr                     (bus_wr),
        .bus_rd                     (bus_rd),
        .bus_rdata                  (bus_rdata),
        .full_duplex_cfg            (full_duplex_cfg),
        .collision_detected         (collision_detected),
        .tx_dma_done_in             (tx_dma_done_in),
        .duplex_indicator_pin       (duplex_indicator_pin),
        .reset_in_progress_out      (reset_in_progress_out),
        .dma_tx_logic_reset         (dma_tx_logic_reset),
        .dma_rx_logic_reset         (dma_rx_logic_reset),
        .area_tx_reset              (area_tx_reset),
        .area_rx_reset              (area_rx_reset),
        .tx_descriptor_list_pointer (tx_ptr),
        .rx_descriptor_list_pointer (rx_ptr),
        .tx_transfer_done_flag      (tx_done_flag)
    );

    srlc_far_side srlc_far_side_inst (
        .ref_clk               (ref_clk),
        .clr                   (clr),
        .pol                   (pol),
        .reset_in_progress_out (reset_in_progress_out),
        .duplex_indicator_pin  (duplex_indicator_pin),
        .rst_cycles            (rst_cycles),
        .lit_cycles            (lit_cycles)
    );

    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        lfsr_state = {lfsr_state[30:0],
                      lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
                      ^ lfsr_state[0]};
        return lfsr_state;
    endfunction : rnd

    // Strobes stay up until the next task or idle lowers them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        bus_rd    <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus_addr <= a;
        bus_wr   <= 1'b0;
        bus_rd   <= 1'b1;
        @(posedge ref_clk);
    endtask : rd

    task automatic idle();
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : idle

    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Read result monitor, looks while the read data stand
    always @(posedge ref_clk) begin
        rd_q <= bus_rd;
    end

    always @(negedge ref_clk) begin
        if (rd_q) begin
            exp_v = exp_q.pop_front();
            `CHK(bus_rdata, exp_v, "read data")
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic run_reset(input logic [3:0] p, input logic pl);
        logic [31:0] tp;
        logic [31:0] rp;
        logic [31:0] w;
        logic [3:0]  area;
        logic        txh;
        logic        rxh;
        logic        dtx;
        logic        drx;
        int          n;
        tp = rnd();
        rp = rnd();
        area = 4'(rnd());
        txh = p[0] | p[2];
        rxh = p[0] | p[1];
        dtx = txh & p[3];
        drx = rxh & p[3];
        w = 32'h0;
        w[14] = 1'b1;
        w[15] = pl;
        w[18:16] = p[2:0];
        w[19] = p[3];
        w[23:20] = area;
        w[24] = !pl;
        wr(srlc_pkg::TXPTR_OFS, tp);
        wr(srlc_pkg::RXPTR_OFS, rp);
        tx_dma_done_in <= 1'b1;
        idle();
        tx_dma_done_in <= 1'b0;
        pol <= pl;
        clr <= 1'b1;
        wr(srlc_pkg::CTRL_OFS, w);
        clr <= 1'b0;
        idle();
        @(negedge ref_clk);
        `CHK(dma_tx_logic_reset, dtx, "dma tx")
        `CHK(dma_rx_logic_reset, drx, "dma rx")
        `CHK(area_tx_reset, txh ? area : 4'h0, "area tx")
        `CHK(area_rx_reset, rxh ? area : 4'h0, "area rx")
        `CHK(reset_in_progress_out, pl, "rst out")
        `CHK(tx_ptr, dtx ? 32'h0 : tp, "tx ptr")
        `CHK(rx_ptr, drx ? 32'h0 : rp, "rx ptr")
        `CHK(tx_done_flag, !dtx, "tx done")
        n = 0;
        while (reset_in_progress_out !== !pl && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(rst_cycles, srlc_pkg::RESET_HOLD_CYCLES + 1, "rst len")
        @(posedge ref_clk);
        rd(srlc_pkg::TXPTR_OFS, dtx ? 32'h0 : tp);
        rd(srlc_pkg::RXPTR_OFS, drx ? 32'h0 : rp);
        rd(srlc_pkg::STAT_OFS, {31'h0, !dtx});
        // Global with output select puts mode and polarity back to 0
        rd(srlc_pkg::CTRL_OFS, {16'h0, pl, !(p[0] & !pl), 14'h0});
        wr(srlc_pkg::STAT_OFS, 32'h1);
        rd(srlc_pkg::STAT_OFS, 32'h0);
    endtask : run_reset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 5000);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(duplex_indicator_pin, 1'b1, "pin idle")
        `CHK(reset_in_progress_out, 1'b1, "rst idle")
        @(posedge ref_clk);
        rd(srlc_pkg::CTRL_OFS, 32'h0);
        rd(OFS_BAD, 32'h0);
        for (int i = 0; i < 5; i++) begin
            run_reset(plan[i], i[0]);
        end
        collision_detected <= 1'b1;
        full_duplex_cfg <= 1'b1;
        wr(srlc_pkg::CTRL_OFS, 32'h0000_4000);
        idle();
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(duplex_indicator_pin, 1'b0, "full duplex")
        @(posedge ref_clk);
        full_duplex_cfg <= 1'b0;
        clr <= 1'b1;
        repeat (2) @(posedge ref_clk);
        clr <= 1'b0;
        repeat (PER * 2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(lit_cycles, 0, "mode one")
        @(posedge ref_clk);
        wr(srlc_pkg::CTRL_OFS, 32'h0);
        clr <= 1'b1;
        idle();
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (PER * 2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(lit_cycles, LOW * 2, "blink")
        @(posedge ref_clk);
        collision_detected <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(duplex_indicator_pin, 1'b1, "dark")
        repeat (3) @(posedge ref_clk);
        end_sim();
    end

endmodule : tb

`default_nettype wire
